// *** design/dscc_pkg.sv ***
package dscc_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CORE_CLK_HZ   = 10_000_000;
  localparam int unsigned CAL_TIME_US   = 200;
  localparam int unsigned CAL_CYCLES    =
    (CAL_TIME_US * (CORE_CLK_HZ / 1_000_000) > 0) ?
    CAL_TIME_US * (CORE_CLK_HZ / 1_000_000) : 1;
  localparam int unsigned CAL_CNT_W     = 12;

  // ----------------------------------------------------------------
  // serial word layout
  // ----------------------------------------------------------------
  localparam int unsigned WORD_BITS     = 24;
  localparam logic [4:0]  BIT_CNT_RST   = 5'h00;
  localparam logic [4:0]  BIT_CNT_LAST  = 5'h17;
  localparam logic [4:0]  BIT_CNT_DONE  = 5'h18;
  localparam int unsigned DATA_MSB      = 15;
  localparam int unsigned PD_LSB        = 6;
  localparam int unsigned PIN_LSB       = 3;
  localparam int unsigned DEF_LSB       = 8;

  // ----------------------------------------------------------------
  // command nibbles and sub-fields
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_REF        = 4'h2;
  localparam logic [3:0] CMD_SOFT       = 4'h3;
  localparam logic [3:0] CMD_POWER      = 4'h4;
  localparam logic [3:0] CMD_PIN_FN     = 4'h5;
  localparam logic [3:0] CMD_DEFAULT    = 4'h6;
  localparam logic [3:0] CMD_RETURN     = 4'h7;
  localparam logic [3:0] CMD_CODE       = 4'h8;
  localparam logic [3:0] CMD_LOAD       = 4'h9;
  localparam logic [3:0] CMD_CODE_LOAD0 = 4'ha;
  localparam logic [3:0] CMD_CODE_LOAD1 = 4'hb;

  localparam logic [2:0] ACT_END_GATE   = 3'h0;
  localparam logic [2:0] ACT_GATE       = 3'h1;
  localparam logic [2:0] ACT_CLEAR      = 3'h4;
  localparam logic [2:0] ACT_REINIT     = 3'h5;

  localparam logic [2:0] PIN_SEL_GATE   = 3'h3;
  localparam logic [2:0] PIN_SEL_CLEAR  = 3'h6;
  localparam logic [2:0] PIN_SEL_OFF    = 3'h7;

  localparam logic [2:0] DEF_SEL_POR    = 3'h0;
  localparam logic [2:0] DEF_SEL_ZERO   = 3'h1;
  localparam logic [2:0] DEF_SEL_MID    = 3'h2;
  localparam logic [2:0] DEF_SEL_FULL   = 3'h3;
  localparam logic [2:0] DEF_SEL_RETURN = 3'h4;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [3:0] REF_RST        = 4'h0;
  localparam logic [1:0] PD_RST         = 2'h0;
  localparam logic [2:0] DEF_RST        = 3'h0;

  typedef enum logic [1:0] {
    DSCC_PIN_CLEAR,
    DSCC_PIN_GATE,
    DSCC_PIN_OFF
  } dscc_pin_fn_type;

  typedef struct packed {
    logic [3:0]  cmd;
    logic [3:0]  sub;
    logic [15:0] data;
  } dscc_word_type;

endpackage

// *** design/dscc_core.sv ***
`timescale 1ns/100ps
`default_nettype none

module dscc_core #(
  parameter int unsigned RES = 12
) (
  input  wire logic                     core_clk,
  input  wire logic                     rst,
  input  wire logic                     sclk,
  input  wire logic                     cs_n,
  input  wire logic                     din,
  input  wire logic                     aux_n,
  input  wire logic                     load_strobe_pin_n,
  output logic [RES-1:0]                dac_out,
  output logic [RES-1:0]                live_code,
  output logic [RES-1:0]                pending_code,
  output logic [RES-1:0]                return_code,
  output logic [3:0]                    ref_cfg,
  output logic [1:0]                    power_mode,
  output dscc_pkg::dscc_pin_fn_type     pin_fn,
  output logic [2:0]                    default_sel,
  output logic                          gate_active,
  output logic                          cal_busy
);

  // ----------------------------------------------------------------
  // link domain: shift register on the falling serial clock
  // ----------------------------------------------------------------
  // select high holds the counter and shifter in reset, so the serial
  // clock is ignored between frames and a short frame just evaporates
  localparam int unsigned WORD_W = dscc_pkg::WORD_BITS;

  logic [4:0]                bit_cnt_q;
  logic [4:0]                bit_cnt_d;
  logic [WORD_W-1:0]         shift_q;
  logic [WORD_W-1:0]         shift_d;
  logic [WORD_W-1:0]         word_q;
  logic                      word_tog_q;
  logic                      last_bit;

  assign last_bit  = (bit_cnt_q == dscc_pkg::BIT_CNT_LAST);
  assign shift_d   = {shift_q[WORD_W-2:0], din};
  assign bit_cnt_d = (bit_cnt_q == dscc_pkg::BIT_CNT_DONE) ?
                     bit_cnt_q : bit_cnt_q + 5'h01;

  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_q <= dscc_pkg::BIT_CNT_RST;
      shift_q   <= '0;
    end else begin
      bit_cnt_q <= bit_cnt_d;
      shift_q   <= shift_d;
    end
  end

  // word and toggle are reset by the core reset only, so they survive
  // the rise of select and stay stable for the core to read
  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      word_q     <= '0;
      word_tog_q <= 1'b0;
    end else if (!cs_n && last_bit) begin
      word_q     <= shift_d;
      word_tog_q <= ~word_tog_q;
    end
  end

  // ----------------------------------------------------------------
  // core domain: synchronisers
  // ----------------------------------------------------------------
  logic [2:0]                tog_sync_q;
  logic [2:0]                cs_sync_q;
  logic [1:0]                aux_sync_q;
  logic [1:0]                load_sync_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tog_sync_q  <= 3'h0;
      cs_sync_q   <= 3'h7;
      aux_sync_q  <= 2'h3;
      load_sync_q <= 2'h3;
    end else begin
      tog_sync_q  <= {tog_sync_q[1:0], word_tog_q};
      cs_sync_q   <= {cs_sync_q[1:0], cs_n};
      aux_sync_q  <= {aux_sync_q[0], aux_n};
      load_sync_q <= {load_sync_q[0], load_strobe_pin_n};
    end
  end

  logic                      word_evt;
  logic                      frame_start;
  logic                      aux_low;
  logic                      load_low;

  assign word_evt    = tog_sync_q[2] ^ tog_sync_q[1];
  assign frame_start = cs_sync_q[2] & ~cs_sync_q[1];
  assign aux_low     = ~aux_sync_q[1];
  assign load_low    = ~load_sync_q[1];

  // ----------------------------------------------------------------
  // calibration window after reset
  // ----------------------------------------------------------------
  localparam logic [dscc_pkg::CAL_CNT_W-1:0] CAL_LOAD =
    dscc_pkg::CAL_CNT_W'(dscc_pkg::CAL_CYCLES);

  logic [dscc_pkg::CAL_CNT_W-1:0] cal_cnt_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cal_cnt_q <= CAL_LOAD;
    end else if (cal_cnt_q != '0) begin
      cal_cnt_q <= cal_cnt_q - dscc_pkg::CAL_CNT_W'(1);
    end
  end

  assign cal_busy = (cal_cnt_q != '0);

  // ----------------------------------------------------------------
  // control and code registers
  // ----------------------------------------------------------------
  logic [RES-1:0]            code_q;
  logic [RES-1:0]            code_d;
  logic [RES-1:0]            dac_q;
  logic [RES-1:0]            dac_d;
  logic [RES-1:0]            ret_q;
  logic [RES-1:0]            ret_d;
  logic [3:0]                ref_q;
  logic [3:0]                ref_d;
  logic [1:0]                pd_q;
  logic [1:0]                pd_d;
  logic [2:0]                def_q;
  logic [2:0]                def_d;
  dscc_pkg::dscc_pin_fn_type pin_q;
  dscc_pkg::dscc_pin_fn_type pin_d;
  logic                      sgate_q;
  logic                      sgate_d;
  logic                      clr_seen_q;
  logic                      clr_seen_d;
  logic [RES-1:0]            out_q;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  dscc_pkg::dscc_word_type   wrd;
  logic                      exec;
  logic                      clear_lvl;
  logic                      gated_ok;
  logic [RES-1:0]            rx_code;
  logic [2:0]                rx_act;
  logic [2:0]                rx_pin;
  logic [2:0]                rx_def;
  logic [RES-1:0]            def_val;
  logic [RES-1:0]            mid_val;
  logic                      def_sel_ok;

  assign wrd        = dscc_pkg::dscc_word_type'(word_q);
  assign exec       = word_evt & ~cal_busy;
  assign clear_lvl  = aux_low & (pin_q == dscc_pkg::DSCC_PIN_CLEAR);
  // low bits below the resolution are simply dropped
  assign rx_code    = wrd.data[dscc_pkg::DATA_MSB -: RES];
  assign rx_act     = wrd.sub[2:0];
  assign rx_pin     = wrd.data[dscc_pkg::PIN_LSB +: 3];
  assign rx_def     = wrd.data[dscc_pkg::DEF_LSB +: 3];
  assign gated_ok   = ~(clr_seen_q | clear_lvl);
  assign mid_val    = {1'b1, {(RES-1){1'b0}}};
  assign def_sel_ok = (rx_def <= dscc_pkg::DEF_SEL_RETURN);

  assign def_val =
    (def_q == dscc_pkg::DEF_SEL_MID)    ? mid_val :
    (def_q == dscc_pkg::DEF_SEL_FULL)   ? {RES{1'b1}} :
    (def_q == dscc_pkg::DEF_SEL_RETURN) ? ret_q :
    {RES{1'b0}};

  // clear activity is remembered from the start of a frame until the
  // next one; a select pulse too short to be seen keeps it conservative
  assign clr_seen_d = frame_start ? clear_lvl :
                      (clr_seen_q | clear_lvl);

  always_comb begin
    code_d  = code_q;
    dac_d   = dac_q;
    ret_d   = ret_q;
    ref_d   = ref_q;
    pd_d    = pd_q;
    def_d   = def_q;
    pin_d   = pin_q;
    sgate_d = sgate_q;
    if (exec) begin
      case (wrd.cmd)
        dscc_pkg::CMD_REF: begin
          ref_d = wrd.sub;
        end
        dscc_pkg::CMD_SOFT: begin
          case (rx_act)
            dscc_pkg::ACT_END_GATE: begin
              sgate_d = 1'b0;
            end
            dscc_pkg::ACT_GATE: begin
              sgate_d = 1'b1;
            end
            dscc_pkg::ACT_CLEAR: begin
              code_d = def_val;
              dac_d  = def_val;
            end
            dscc_pkg::ACT_REINIT: begin
              code_d  = '0;
              dac_d   = '0;
              ret_d   = '0;
              ref_d   = dscc_pkg::REF_RST;
              pd_d    = dscc_pkg::PD_RST;
              def_d   = dscc_pkg::DEF_RST;
              pin_d   = dscc_pkg::DSCC_PIN_CLEAR;
              sgate_d = 1'b0;
            end
            default: begin
            end
          endcase
        end
        dscc_pkg::CMD_POWER: begin
          // power-down touches no code register
          pd_d = wrd.data[dscc_pkg::PD_LSB +: 2];
        end
        dscc_pkg::CMD_PIN_FN: begin
          case (rx_pin)
            dscc_pkg::PIN_SEL_GATE: begin
              pin_d = dscc_pkg::DSCC_PIN_GATE;
            end
            dscc_pkg::PIN_SEL_CLEAR: begin
              pin_d = dscc_pkg::DSCC_PIN_CLEAR;
            end
            dscc_pkg::PIN_SEL_OFF: begin
              pin_d = dscc_pkg::DSCC_PIN_OFF;
            end
            default: begin
            end
          endcase
        end
        dscc_pkg::CMD_DEFAULT: begin
          if (def_sel_ok) begin
            def_d = rx_def;
          end
        end
        dscc_pkg::CMD_RETURN: begin
          ret_d = rx_code;
        end
        dscc_pkg::CMD_CODE: begin
          if (gated_ok) begin
            code_d = rx_code;
          end
        end
        dscc_pkg::CMD_LOAD: begin
          if (gated_ok) begin
            dac_d = code_q;
          end
        end
        dscc_pkg::CMD_CODE_LOAD0,
        dscc_pkg::CMD_CODE_LOAD1: begin
          if (gated_ok) begin
            code_d = rx_code;
            dac_d  = rx_code;
          end
        end
        default: begin
        end
      endcase
    end
    // a low load pin passes the new pending value in the same edge,
    // so a held-low pin makes every code write visible at once
    if (load_low) begin
      dac_d = code_d;
    end
    // clear level wins over everything that writes the pending and live code registers
    if (clear_lvl) begin
      code_d = def_val;
      dac_d  = def_val;
    end
  end

  // ----------------------------------------------------------------
  // register update
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      code_q <= '0;
      dac_q  <= '0;
      ret_q  <= '0;
    end else begin
      code_q <= code_d;
      dac_q  <= dac_d;
      ret_q  <= ret_d;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ref_q   <= dscc_pkg::REF_RST;
      pd_q    <= dscc_pkg::PD_RST;
      def_q   <= dscc_pkg::DEF_RST;
      pin_q   <= dscc_pkg::DSCC_PIN_CLEAR;
      sgate_q <= 1'b0;
    end else begin
      ref_q   <= ref_d;
      pd_q    <= pd_d;
      def_q   <= def_d;
      pin_q   <= pin_d;
      sgate_q <= sgate_d;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      clr_seen_q <= 1'b0;
    end else begin
      clr_seen_q <= clr_seen_d;
    end
  end

  // ----------------------------------------------------------------
  // output stage
  // ----------------------------------------------------------------
  // gating only masks the output; the live latch keeps tracking so the
  // release returns straight to the latest code
  logic                      gate_lvl;
  logic [RES-1:0]            out_d;

  assign gate_lvl = sgate_q |
                    (aux_low & (pin_q == dscc_pkg::DSCC_PIN_GATE));
  assign out_d    = gate_lvl ? def_val : dac_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      out_q <= '0;
    end else begin
      out_q <= out_d;
    end
  end

  assign dac_out      = out_q;
  assign live_code    = dac_q;
  assign pending_code = code_q;
  assign return_code  = ret_q;
  assign ref_cfg      = ref_q;
  assign power_mode   = pd_q;
  assign pin_fn       = pin_q;
  assign default_sel  = def_q;
  assign gate_active  = gate_lvl;

endmodule

`default_nettype wire

// *** design/dscc_unused_placeholder_never.sv ***
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// *** tb/dscc_core_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none

module dscc_core_asserts #(
  parameter int unsigned RES = 12
) (
  input wire logic                      core_clk,
  input wire logic                      rst,
  input wire logic                      sclk,
  input wire logic                      cs_n,
  input wire logic                      din,
  input wire logic                      aux_n,
  input wire logic                      load_strobe_pin_n,
  input wire logic [RES-1:0]            dac_out,
  input wire logic [RES-1:0]            live_code,
  input wire logic [RES-1:0]            pending_code,
  input wire logic [RES-1:0]            return_code,
  input wire logic [3:0]                ref_cfg,
  input wire logic [1:0]                power_mode,
  input wire dscc_pkg::dscc_pin_fn_type pin_fn,
  input wire logic [2:0]                default_sel,
  input wire logic                      gate_active,
  input wire logic                      cal_busy
);
  logic [11:0]    since_q;
  logic [RES-1:0] def_val;
  logic           is_clr;
  logic           is_gate;

  assign is_clr  = pin_fn == dscc_pkg::DSCC_PIN_CLEAR;
  assign is_gate = pin_fn == dscc_pkg::DSCC_PIN_GATE;
  assign def_val = (default_sel == dscc_pkg::DEF_SEL_MID) ?
                   {1'b1, {(RES-1){1'b0}}} :
                   (default_sel == dscc_pkg::DEF_SEL_FULL) ? '1 :
                   (default_sel == dscc_pkg::DEF_SEL_RETURN) ?
                   return_code : '0;

  // saturates so the calibration window is judged once per reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      since_q <= 12'h000;
    end else if (since_q != 12'hfff) begin
      since_q <= since_q + 12'h001;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  cal_hold_a: assert property (since_q < 12'h7c6 |-> cal_busy)
    else $error("calibration ended early");
  cal_end_a: assert property (since_q > 12'h7da |-> !cal_busy)
    else $error("calibration did not end");
  por_zero_a: assert property (
    cal_busy |-> live_code == '0 && pending_code == '0)
    else $error("codes not zero during calibration");
  cfg_quiet_a: assert property (
    cal_busy |-> $stable(ref_cfg) && $stable(power_mode) &&
    $stable(pin_fn))
    else $error("configuration changed during calibration");
  dac_live_a: assert property (
    !$past(gate_active) |-> dac_out == $past(live_code))
    else $error("output does not follow live code");
  dac_gate_a: assert property (
    $past(gate_active) |-> dac_out == $past(def_val))
    else $error("gated output is not the default value");
  load_follow_a: assert property (
    (!load_strobe_pin_n)[*4] |-> live_code == pending_code)
    else $error("live code not following pending code");
  clear_force_a: assert property (
    (is_clr && !aux_n)[*5] ##0
    ($stable(default_sel) && $stable(return_code)) |->
    pending_code == def_val && live_code == def_val)
    else $error("clear pin did not force default");
  gate_pin_a: assert property (
    (is_gate && !aux_n)[*4] |-> gate_active)
    else $error("gate pin not honoured");
endmodule

bind dscc_core dscc_core_asserts #(.RES(RES)) i_dscc_core_asserts (
  .core_clk(core_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din),
  .aux_n(aux_n), .load_strobe_pin_n(load_strobe_pin_n),
  .dac_out(dac_out), .live_code(live_code), .pending_code(pending_code),
  .return_code(return_code), .ref_cfg(ref_cfg), .power_mode(power_mode),
  .pin_fn(pin_fn), .default_sel(default_sel), .gate_active(gate_active),
  .cal_busy(cal_busy)
);

`default_nettype wire

// *** tb/dscc_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none

module dscc_host_model (
  output logic            sclk,
  output logic            cs_n,
  output logic            din,
  output logic            ack,
  input wire logic        req,
  input wire logic        slow,
  input wire logic [23:0] word,
  input wire logic [4:0]  nbits
);
  int i;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
    ack = 1'b0;
  end

  // link clock runs only inside a frame, 80 ns period, or 160 ns when slow is set
  always begin
    wait (req === 1'b1);
    #13;
    cs_n = 1'b0;
    for (i = 0; i < nbits; i++) begin
      #40 sclk = 1'b1;
      din = (i < 24) ? word[23-i] : ~din;
      #(slow ? 120 : 40) sclk = 1'b0;
    end
    #20 cs_n = 1'b1;
    din = ~din;
    ack = 1'b1;
    wait (req === 1'b0);
    ack = 1'b0;
  end
endmodule

`default_nettype wire

// *** tb/tb_dac_serial_command_control.sv ***
`timescale 1ns/100ps
`default_nettype none

module tb_dac_serial_command_control;
  localparam int RES = 12;
  logic                      core_clk;
  logic                      rst;
  logic                      sclk;
  logic                      cs_n;
  logic                      din;
  logic                      aux_n;
  logic                      load_strobe_pin_n;
  logic                      req;
  logic                      slow;
  logic                      ack;
  logic [23:0]               word;
  logic [4:0]                nbits;
  logic [RES-1:0]            dac_out;
  logic [RES-1:0]            live_code;
  logic [RES-1:0]            pending_code;
  logic [RES-1:0]            return_code;
  logic [3:0]                ref_cfg;
  logic [1:0]                power_mode;
  dscc_pkg::dscc_pin_fn_type pin_fn;
  logic [2:0]                default_sel;
  logic                      gate_active;
  logic                      cal_busy;
  int                        n_mismatch;
  int                        comparisons;
  int                        k;

  dscc_core #(.RES(RES)) i_dscc_core (
    .core_clk(core_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din),
    .aux_n(aux_n), .load_strobe_pin_n(load_strobe_pin_n),
    .dac_out(dac_out), .live_code(live_code), .pending_code(pending_code),
    .return_code(return_code), .ref_cfg(ref_cfg), .power_mode(power_mode),
    .pin_fn(pin_fn), .default_sel(default_sel), .gate_active(gate_active),
    .cal_busy(cal_busy)
  );

  dscc_host_model i_dscc_host_model (
    .sclk(sclk), .cs_n(cs_n), .din(din), .ack(ack), .req(req),
    .slow(slow), .word(word), .nbits(nbits)
  );

  initial core_clk = 1'b0;
  always #50 core_clk = ~core_clk;

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic cc(input logic [15:0] p, input logic [15:0] l);
    chk("pending_code", p, 16'(pending_code));
    chk("live_code", l, 16'(live_code));
  endtask

  // one framed word; waits well past the few-cycle update latency
  task automatic wr(input logic [23:0] w, input logic [4:0] n);
    int t;
    @(negedge core_clk);
    word = w;
    nbits = n;
    req = 1'b1;
    t = 0;
    while (ack !== 1'b1 && t < 200) begin
      @(negedge core_clk);
      t++;
    end
    chk("frame_ack", 16'h0001, 16'(ack));
    req = 1'b0;
    repeat (8) @(negedge core_clk);
  endtask

  task automatic pins(input logic a, input logic l);
    @(negedge core_clk);
    aux_n = a;
    load_strobe_pin_n = l;
    repeat (6) @(negedge core_clk);
  endtask

  task automatic test_done;
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #2_000_000;
    n_mismatch++;
    test_done;
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    aux_n = 1'b1;
    load_strobe_pin_n = 1'b1;
    req = 1'b0;
    slow = 1'b0;
    word = 24'h000000;
    nbits = 5'h18;
    n_mismatch = 0;
    comparisons = 0;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    cc(16'h0000, 16'h0000);
    chk("pin_fn", 16'(dscc_pkg::DSCC_PIN_CLEAR), 16'(pin_fn));
    wr(24'ha0abc0, 5'h18);
    cc(16'h0000, 16'h0000);
    k = 0;
    while (cal_busy !== 1'b0 && k < 3000) begin
      @(negedge core_clk);
      k++;
    end
    chk("cal_busy", 16'h0000, 16'(cal_busy));
    wr(24'h8f1230, 5'h18);
    cc(16'h0123, 16'h0000);
    wr(24'h900000, 5'h18);
    cc(16'h0123, 16'h0123);
    chk("dac_out", 16'h0123, 16'(dac_out));
    wr(24'ha04560, 5'h1a);
    cc(16'h0456, 16'h0456);
    slow = 1'b1;
    wr(24'hb07890, 5'h1f);
    slow = 1'b0;
    cc(16'h0789, 16'h0789);
    wr(24'ha0fff0, 5'h17);
    cc(16'h0789, 16'h0789);
    for (k = 0; k < 16; k++) begin
      if (k < 2 || k > 11) begin
        wr({4'(k), 20'hffff0}, 5'h18);
      end
    end
    cc(16'h0789, 16'h0789);
    pins(1'b1, 1'b0);
    wr(24'h803450, 5'h18);
    cc(16'h0345, 16'h0345);
    pins(1'b1, 1'b1);
    wr(24'h805670, 5'h18);
    cc(16'h0567, 16'h0345);
    pins(1'b1, 1'b0);
    pins(1'b1, 1'b1);
    cc(16'h0567, 16'h0567);
    wr(24'h600300, 5'h18);
    wr(24'h340000, 5'h18);
    cc(16'h0fff, 16'h0fff);
    wr(24'h600200, 5'h18);
    pins(1'b0, 1'b1);
    cc(16'h0800, 16'h0800);
    chk("default_sel", 16'h0002, 16'(default_sel));
    for (k = 8; k < 12; k++) begin
      wr({4'(k), 20'h01110}, 5'h18);
    end
    cc(16'h0800, 16'h0800);
    wr(24'h400040, 5'h18);
    chk("power_mode", 16'h0001, 16'(power_mode));
    // clear released inside the frame: the word must still be dropped
    fork
      wr(24'ha03330, 5'h18);
      begin
        repeat (6) @(negedge core_clk);
        aux_n = 1'b1;
      end
    join
    cc(16'h0800, 16'h0800);
    wr(24'ha01110, 5'h18);
    cc(16'h0111, 16'h0111);
    wr(24'h802220, 5'h18);
    wr(24'h900000, 5'h18);
    cc(16'h0222, 16'h0222);
    wr(24'h500018, 5'h18);
    wr(24'h500008, 5'h18);
    chk("pin_fn", 16'(dscc_pkg::DSCC_PIN_GATE), 16'(pin_fn));
    pins(1'b0, 1'b1);
    chk("dac_out", 16'h0800, 16'(dac_out));
    wr(24'hb09ab0, 5'h18);
    cc(16'h09ab, 16'h09ab);
    wr(24'h705550, 5'h18);
    wr(24'h600400, 5'h18);
    chk("dac_out", 16'h0555, 16'(dac_out));
    wr(24'h600700, 5'h18);
    chk("default_sel", 16'h0004, 16'(default_sel));
    pins(1'b1, 1'b1);
    chk("dac_out", 16'h09ab, 16'(dac_out));
    wr(24'h500038, 5'h18);
    pins(1'b0, 1'b1);
    chk("gate_active", 16'h0000, 16'(gate_active));
    cc(16'h09ab, 16'h09ab);
    pins(1'b1, 1'b1);
    wr(24'h500030, 5'h18);
    chk("pin_fn", 16'(dscc_pkg::DSCC_PIN_CLEAR), 16'(pin_fn));
    wr(24'h310000, 5'h18);
    chk("dac_out", 16'h0555, 16'(dac_out));
    for (k = 2; k < 8; k++) begin
      if (k != 4 && k != 5) begin
        wr({5'h06, 3'(k), 16'h0000}, 5'h18);
      end
    end
    chk("gate_active", 16'h0001, 16'(gate_active));
    wr(24'h300000, 5'h18);
    chk("dac_out", 16'h09ab, 16'(dac_out));
    wr(24'h2f0000, 5'h18);
    chk("ref_cfg", 16'h000f, 16'(ref_cfg));
    wr(24'h400080, 5'h18);
    chk("power_mode", 16'h0002, 16'(power_mode));
    wr(24'h500018, 5'h18);
    wr(24'h350000, 5'h18);
    cc(16'h0000, 16'h0000);
    chk("ref_cfg", 16'h0000, 16'(ref_cfg));
    chk("power_mode", 16'h0000, 16'(power_mode));
    chk("pin_fn", 16'(dscc_pkg::DSCC_PIN_CLEAR), 16'(pin_fn));
    chk("default_sel", 16'h0000, 16'(default_sel));
    chk("return_code", 16'h0000, 16'(return_code));
    test_done;
  end
endmodule

`default_nettype wire
